// *** rtl/clock_alarm_pkg.sv ***
// constants, types and register map of the clock alarm and status pin block
// Behaviour
// - global offset enable low suppresses all offset alarms; high defers to per-input enables
// - two-bit threshold picks trip point 11-12, 48-49, 30 or 200 ppm
// - input must stay valid 2 ms, 100 ms, 200 ms or 13 s before alarm clears
// - phase slip retriggers lock one-shot; interval 106 ms halving down to 1.66 ms
// - clock-2-bad pin enable low tristates that pin, high shows clock-2-bad status
// - clock-1-bad enable low tristates shared pin, high shows input-1 loss or interrupt
// - lock-loss pin enable low tristates lock pin, high shows lock-loss status
// - interrupt-select high shows interrupt on shared pin, low shows input-1 bad
// - active pin enable drives clock-1-active on select pin, only without pin selection
// - in manual mode, selection source picks register field or selection pin
// - active-clock polarity bit sets asserted level of select/active pin output
// - clock-bad polarity bit sets asserted level of both clock-bad pins
// - lock-loss polarity bit sets asserted level of the lock-loss pin
// - interrupt polarity bit sets asserted level of interrupt on shared pin
// - alarm configuration register resets to 0x2C
// - pin enable register resets to 0x3E, all status pin enables set
// - offset reference select 000 external, 001 input one, 010 input two, others reserved
// - loss mask low lets alarm raise interrupt; mask writes never alter alarms
package clock_alarm_pkg;

  localparam logic [7:0] ADDR_OFFSET_REF = 8'h07;
  localparam logic [7:0] ADDR_ALARM_CFG  = 8'h13;
  localparam logic [7:0] ADDR_PIN_EN     = 8'h14;
  localparam logic [7:0] ADDR_SEL_CTRL   = 8'h15;
  localparam logic [7:0] ADDR_POLARITY   = 8'h16;
  localparam logic [7:0] ADDR_LOSS_MASK  = 8'h17;

  localparam logic [7:0] RST_OFFSET_REF = 8'h2A;
  localparam logic [7:0] RST_ALARM_CFG  = 8'h2C;
  localparam logic [7:0] RST_PIN_EN     = 8'h3E;
  localparam logic [7:0] RST_SEL_CTRL   = 8'hFF;
  localparam logic [7:0] RST_POLARITY   = 8'hDF;
  localparam logic [7:0] RST_LOSS_MASK  = 8'h1F;

  localparam logic [7:0] RW_OFFSET_REF = 8'h07;
  localparam logic [7:0] RW_ALARM_CFG  = 8'hFF;
  localparam logic [7:0] RW_PIN_EN     = 8'h0F;
  localparam logic [7:0] RW_SEL_CTRL   = 8'h03;
  localparam logic [7:0] RW_POLARITY   = 8'h0F;
  localparam logic [7:0] RW_LOSS_MASK  = 8'h07;

  localparam int BIT_CLOCK2_BAD_EN  = 3;
  localparam int BIT_CLOCK1_BAD_EN  = 2;
  localparam int BIT_LOCK_LOSS_EN   = 1;
  localparam int BIT_INT_SELECT     = 0;
  localparam int BIT_ACTIVE_PIN_EN  = 1;
  localparam int BIT_SOURCE_PIN     = 0;
  localparam int BIT_ACTIVE_POL     = 3;
  localparam int BIT_BAD_POL        = 2;
  localparam int BIT_LOCK_POL       = 1;
  localparam int BIT_IRQ_POL        = 0;
  localparam int LOSS_X             = 0;
  localparam int LOSS_1             = 1;
  localparam int LOSS_2             = 2;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_US  = 10;
  localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W       = 21;

  typedef logic [TIMER_W-1:0] timer_t;

  localparam int VALID_US   [4] = '{2000, 100000, 200000, 13000000};
  localparam int RETRIG_US  [7] = '{106000, 53000, 26500, 13300, 6600, 3300, 1660};
  localparam logic [7:0] THRESHOLD_PPM [4] = '{8'h0C, 8'h31, 8'h1E, 8'hC8};

  typedef struct packed {
    logic       global_en;
    logic [1:0] threshold;
    logic [1:0] validation;
    logic [2:0] retrigger;
  } alarm_cfg_s;

  typedef enum logic [1:0] {
    ST_ALARM = 2'b00,
    ST_CHECK = 2'b01,
    ST_GOOD  = 2'b11
  } valid_state_e;

  // least time, rounded up to whole ticks
  function automatic timer_t validation_ticks(input logic [1:0] code);
    validation_ticks = TIMER_W'((VALID_US[code] + TICK_TIME_US - 1) / TICK_TIME_US);
  endfunction : validation_ticks

  function automatic timer_t retrig_ticks(input logic [2:0] code);
    logic [2:0] idx;
    idx = (code == 3'h7) ? 3'h0 : code;
    retrig_ticks = TIMER_W'(RETRIG_US[idx] / TICK_TIME_US);
  endfunction : retrig_ticks

endpackage : clock_alarm_pkg

// *** rtl/alarm_validator.sv ***
// holds one alarm until its input has stayed clean for the validation time
module alarm_validator
  import clock_alarm_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    tick_i,
  input  wire logic                    raw_alarm_i,
  input  wire clock_alarm_pkg::timer_t hold_ticks_i,
  output logic                         alarm_o
);
  import clock_alarm_pkg::*;

  valid_state_e state;
  valid_state_e next_state;
  timer_t       count;
  timer_t       next_count;
  logic         next_alarm;

  ////////////////////////////////////////////////////////////////////////////
  // validation timing
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      ST_ALARM: begin
        next_count = '0;
        if (!raw_alarm_i) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (raw_alarm_i) begin
          next_state = ST_ALARM;
        end else if (tick_i) begin
          next_count = count + TIMER_W'(1);
          if (next_count >= hold_ticks_i) begin
            next_state = ST_GOOD;
          end
        end
      end
      ST_GOOD: begin
        if (raw_alarm_i) begin
          next_state = ST_ALARM;
        end
      end
      default: begin
        next_state = ST_ALARM;
      end
    endcase
    next_alarm = (next_state != ST_GOOD);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state   <= ST_ALARM;
      count   <= '0;
      alarm_o <= 1'b1;
    end else begin
      state   <= next_state;
      count   <= next_count;
      alarm_o <= next_alarm;
    end
  end

  a_alarm_sets_fast: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    raw_alarm_i |=> alarm_o) else $error("alarm not raised after raw alarm");
  a_alarm_clears_late: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(alarm_o) |-> $past(state) == ST_CHECK && $past(count) + 1 >= $past(hold_ticks_i))
    else $error("alarm cleared before validation time");

endmodule : alarm_validator

// *** rtl/lock_monitor.sv ***
// retriggerable one-shot that flags lock loss after each phase slip
module lock_monitor
  import clock_alarm_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    tick_i,
  input  wire logic                    slip_i,
  input  wire clock_alarm_pkg::timer_t interval_ticks_i,
  output logic                         lock_loss_o
);
  import clock_alarm_pkg::*;

  timer_t count;
  timer_t next_count;
  logic   next_lock_loss;

  ////////////////////////////////////////////////////////////////////////////
  // retrigger one-shot
  always_comb begin
    next_count = count;
    if (slip_i) begin
      next_count = interval_ticks_i;
    end else if (tick_i && count != '0) begin
      next_count = count - TIMER_W'(1);
    end
    next_lock_loss = (next_count != '0);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count       <= '0;
      lock_loss_o <= 1'b0;
    end else begin
      count       <= next_count;
      lock_loss_o <= next_lock_loss;
    end
  end

  a_slip_starts_shot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    slip_i |=> lock_loss_o && count == $past(interval_ticks_i)) else $error("slip did not retrigger");

endmodule : lock_monitor

// *** rtl/clock_alarm_status_pins.sv ***
// alarm configuration registers and status pin drivers of the clock multiplier
module clock_alarm_status_pins
  import clock_alarm_pkg::*;
#(
  parameter int TICK_CYCLES_P = clock_alarm_pkg::TICK_CYCLES
) (
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic [2:0] SIGNAL_LOSS_RAW_I,
  input  wire logic [1:0] FREQ_OFFSET_RAW_I,
  input  wire logic [1:0] PER_INPUT_OFFSET_ENABLE_I,
  input  wire logic       PHASE_SLIP_I,
  input  wire logic       CLOCK1_ACTIVE_STATUS_I,
  input  wire logic       AUTO_SELECTION_MODE_I,
  input  wire logic [1:0] REGISTER_CLOCK_SELECT_I,
  input  wire logic [1:0] AUTO_CLOCK_SELECT_I,
  input  wire logic       SELECT_ACTIVE_PIN_I,
  output logic      [2:0] SIGNAL_LOSS_ALARM_O,
  output logic      [1:0] FREQUENCY_OFFSET_ALARM_O,
  output logic            LOCK_LOSS_O,
  output logic      [7:0] OFFSET_THRESHOLD_PPM_O,
  output logic      [2:0] OFFSET_REFERENCE_SELECT_O,
  output logic      [1:0] SELECTED_CLOCK_O,
  output logic            CLOCK2_BAD_OUTPUT_O,
  output logic            CLOCK2_BAD_OUTPUT_OE_O,
  output logic            SHARED_INTERRUPT_CLOCK1_BAD_PIN_O,
  output logic            SHARED_INTERRUPT_CLOCK1_BAD_PIN_OE_O,
  output logic            LOCK_LOSS_PIN_O,
  output logic            LOCK_LOSS_PIN_OE_O,
  output logic            SELECT_ACTIVE_PIN_O,
  output logic            SELECT_ACTIVE_PIN_OE_O
);
  import clock_alarm_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES_P + 1);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] offset_ref;
  logic [7:0] alarm_reg;
  logic [7:0] pin_en;
  logic [7:0] sel_ctrl;
  logic [7:0] polarity;
  logic [7:0] loss_mask;
  logic [7:0] next_offset_ref;
  logic [7:0] next_alarm_reg;
  logic [7:0] next_pin_en;
  logic [7:0] next_sel_ctrl;
  logic [7:0] next_polarity;
  logic [7:0] next_loss_mask;
  logic [7:0] next_rdata;
  alarm_cfg_s alarm_cfg;

  assign alarm_cfg = alarm_cfg_s'(alarm_reg);

  // read-only bits always return their reset value
  function automatic logic [7:0] merge(input logic [7:0] rst, input logic [7:0] rw, input logic [7:0] wd);
    merge = (rst & ~rw) | (wd & rw);
  endfunction : merge

  always_comb begin
    next_offset_ref = offset_ref;
    next_alarm_reg  = alarm_reg;
    next_pin_en     = pin_en;
    next_sel_ctrl   = sel_ctrl;
    next_polarity   = polarity;
    next_loss_mask  = loss_mask;
    next_rdata      = REG_RDATA_O;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_OFFSET_REF: next_offset_ref = merge(RST_OFFSET_REF, RW_OFFSET_REF, REG_WDATA_I);
        ADDR_ALARM_CFG:  next_alarm_reg  = merge(RST_ALARM_CFG, RW_ALARM_CFG, REG_WDATA_I);
        ADDR_PIN_EN:     next_pin_en     = merge(RST_PIN_EN, RW_PIN_EN, REG_WDATA_I);
        ADDR_SEL_CTRL:   next_sel_ctrl   = merge(RST_SEL_CTRL, RW_SEL_CTRL, REG_WDATA_I);
        ADDR_POLARITY:   next_polarity   = merge(RST_POLARITY, RW_POLARITY, REG_WDATA_I);
        ADDR_LOSS_MASK:  next_loss_mask  = merge(RST_LOSS_MASK, RW_LOSS_MASK, REG_WDATA_I);
        default: begin
        end
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_OFFSET_REF: next_rdata = offset_ref;
        ADDR_ALARM_CFG:  next_rdata = alarm_reg;
        ADDR_PIN_EN:     next_rdata = pin_en;
        ADDR_SEL_CTRL:   next_rdata = sel_ctrl;
        ADDR_POLARITY:   next_rdata = polarity;
        ADDR_LOSS_MASK:  next_rdata = loss_mask;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      offset_ref  <= RST_OFFSET_REF;
      alarm_reg   <= RST_ALARM_CFG;
      pin_en      <= RST_PIN_EN;
      sel_ctrl    <= RST_SEL_CTRL;
      polarity    <= RST_POLARITY;
      loss_mask   <= RST_LOSS_MASK;
      REG_RDATA_O <= 8'h00;
    end else begin
      offset_ref  <= next_offset_ref;
      alarm_reg   <= next_alarm_reg;
      pin_en      <= next_pin_en;
      sel_ctrl    <= next_sel_ctrl;
      polarity    <= next_polarity;
      loss_mask   <= next_loss_mask;
      REG_RDATA_O <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick divider and pin synchroniser

  logic [DIV_W-1:0] div_count;
  logic [DIV_W-1:0] next_div_count;
  logic             tick;
  logic             next_tick;
  logic             pin_meta;
  logic             pin_sync;

  always_comb begin
    next_tick      = (div_count == DIV_W'(TICK_CYCLES_P - 1));
    next_div_count = next_tick ? '0 : div_count + DIV_W'(1);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_count <= '0;
      tick      <= 1'b0;
      pin_meta  <= 1'b0;
      pin_sync  <= 1'b0;
    end else begin
      div_count <= next_div_count;
      tick      <= next_tick;
      pin_meta  <= SELECT_ACTIVE_PIN_I;
      pin_sync  <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm validation and lock monitor

  logic [4:0] raw_alarms;
  logic [4:0] held_alarms;
  timer_t     hold_ticks;
  timer_t     retrig;
  logic       lock_loss;

  assign raw_alarms = {FREQ_OFFSET_RAW_I, SIGNAL_LOSS_RAW_I};
  assign hold_ticks = validation_ticks(alarm_cfg.validation);
  assign retrig     = retrig_ticks(alarm_cfg.retrigger);

  for (genvar g = 0; g < 5; g++) begin : g_valid
    alarm_validator u_valid (
      .clk_i        (CLK_I),
      .arst_n_i     (ARST_N_I),
      .tick_i       (tick),
      .raw_alarm_i  (raw_alarms[g]),
      .hold_ticks_i (hold_ticks),
      .alarm_o      (held_alarms[g])
    );
  end

  lock_monitor u_lock (
    .clk_i            (CLK_I),
    .arst_n_i         (ARST_N_I),
    .tick_i           (tick),
    .slip_i           (PHASE_SLIP_I),
    .interval_ticks_i (retrig),
    .lock_loss_o      (lock_loss)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status outputs and pin drivers

  logic [1:0] next_offset_alarm;
  logic       clock2_bad;
  logic       interrupt;
  logic       pin_select;
  logic [1:0] next_selected;
  logic [7:0] next_ppm;
  logic [2:0] next_ref;
  logic       next_clk2_pin;
  logic       next_clk2_oe;
  logic       next_shared;
  logic       next_shared_oe;
  logic       next_lock_pin;
  logic       next_lock_oe;
  logic       next_act;
  logic       next_act_oe;

  always_comb begin
    next_offset_alarm = held_alarms[4:3] & PER_INPUT_OFFSET_ENABLE_I & {2{alarm_cfg.global_en}};
    clock2_bad        = held_alarms[LOSS_2] | next_offset_alarm[1];
    interrupt         = |(held_alarms[2:0] & ~loss_mask[2:0]);
    next_ppm          = THRESHOLD_PPM[alarm_cfg.threshold];
    next_ref          = (offset_ref[2:0] > 3'h2) ? 3'h0 : offset_ref[2:0];
    pin_select        = !AUTO_SELECTION_MODE_I && sel_ctrl[BIT_SOURCE_PIN];
    if (AUTO_SELECTION_MODE_I) begin
      next_selected = AUTO_CLOCK_SELECT_I;
    end else if (pin_select) begin
      next_selected = {1'b0, pin_sync};
    end else begin
      next_selected = REGISTER_CLOCK_SELECT_I;
    end
    next_clk2_oe   = pin_en[BIT_CLOCK2_BAD_EN];
    next_clk2_pin  = clock2_bad ~^ polarity[BIT_BAD_POL];
    next_shared_oe = pin_en[BIT_CLOCK1_BAD_EN];
    if (pin_en[BIT_INT_SELECT]) begin
      next_shared = interrupt ~^ polarity[BIT_IRQ_POL];
    end else begin
      next_shared = held_alarms[LOSS_1] ~^ polarity[BIT_BAD_POL];
    end
    next_lock_oe  = pin_en[BIT_LOCK_LOSS_EN];
    next_lock_pin = lock_loss ~^ polarity[BIT_LOCK_POL];
    next_act_oe   = sel_ctrl[BIT_ACTIVE_PIN_EN] && !pin_select;
    next_act      = CLOCK1_ACTIVE_STATUS_I ~^ polarity[BIT_ACTIVE_POL];
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SIGNAL_LOSS_ALARM_O                  <= 3'h7;
      FREQUENCY_OFFSET_ALARM_O             <= 2'h0;
      LOCK_LOSS_O                          <= 1'b0;
      OFFSET_THRESHOLD_PPM_O               <= 8'h00;
      OFFSET_REFERENCE_SELECT_O            <= 3'h0;
      SELECTED_CLOCK_O                     <= 2'h0;
      CLOCK2_BAD_OUTPUT_O                  <= 1'b0;
      CLOCK2_BAD_OUTPUT_OE_O               <= 1'b0;
      SHARED_INTERRUPT_CLOCK1_BAD_PIN_O    <= 1'b0;
      SHARED_INTERRUPT_CLOCK1_BAD_PIN_OE_O <= 1'b0;
      LOCK_LOSS_PIN_O                      <= 1'b0;
      LOCK_LOSS_PIN_OE_O                   <= 1'b0;
      SELECT_ACTIVE_PIN_O                  <= 1'b0;
      SELECT_ACTIVE_PIN_OE_O               <= 1'b0;
    end else begin
      SIGNAL_LOSS_ALARM_O                  <= held_alarms[2:0];
      FREQUENCY_OFFSET_ALARM_O             <= next_offset_alarm;
      LOCK_LOSS_O                          <= lock_loss;
      OFFSET_THRESHOLD_PPM_O               <= next_ppm;
      OFFSET_REFERENCE_SELECT_O            <= next_ref;
      SELECTED_CLOCK_O                     <= next_selected;
      CLOCK2_BAD_OUTPUT_O                  <= next_clk2_pin;
      CLOCK2_BAD_OUTPUT_OE_O               <= next_clk2_oe;
      SHARED_INTERRUPT_CLOCK1_BAD_PIN_O    <= next_shared;
      SHARED_INTERRUPT_CLOCK1_BAD_PIN_OE_O <= next_shared_oe;
      LOCK_LOSS_PIN_O                      <= next_lock_pin;
      LOCK_LOSS_PIN_OE_O                   <= next_lock_oe;
      SELECT_ACTIVE_PIN_O                  <= next_act;
      SELECT_ACTIVE_PIN_OE_O               <= next_act_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_pin_mode;
    !AUTO_SELECTION_MODE_I && sel_ctrl[BIT_SOURCE_PIN];
  endsequence

  a_offset_global_gate: assert property (
    !alarm_cfg.global_en |=> FREQUENCY_OFFSET_ALARM_O == 2'h0) else $error("offset alarm not suppressed");
  a_threshold_top_code: assert property (
    alarm_cfg.threshold == 2'h3 |=> OFFSET_THRESHOLD_PPM_O == THRESHOLD_PPM[3]) else $error("threshold wrong");
  a_clock2_pin_drive: assert property (
    ARST_N_I |=> CLOCK2_BAD_OUTPUT_OE_O == $past(pin_en[BIT_CLOCK2_BAD_EN])) else $error("clock2 pin enable");
  a_shared_pin_tristate: assert property (
    !pin_en[BIT_CLOCK1_BAD_EN] |=> !SHARED_INTERRUPT_CLOCK1_BAD_PIN_OE_O) else $error("shared pin driven");
  a_lock_pin_drive: assert property (
    ARST_N_I && pin_en[BIT_LOCK_LOSS_EN] |=>
    LOCK_LOSS_PIN_OE_O && (LOCK_LOSS_PIN_O == ($past(lock_loss) ~^ $past(polarity[1]))))
    else $error("lock pin wrong");
  a_shared_int_level: assert property (
    pin_en[BIT_INT_SELECT] |=> SHARED_INTERRUPT_CLOCK1_BAD_PIN_O == ($past(interrupt) ~^ $past(polarity[0])))
    else $error("interrupt not on shared pin");
  a_active_pin_mode: assert property (
    s_pin_mode |=> !SELECT_ACTIVE_PIN_OE_O) else $error("active pin driven in pin mode");
  a_select_from_pin: assert property (
    s_pin_mode ##0 !$past(AUTO_SELECTION_MODE_I) |=> SELECTED_CLOCK_O == {1'b0, $past(pin_sync)})
    else $error("pin selection ignored");
  a_bad_pin_polarity: assert property (
    !polarity[BIT_BAD_POL] && clock2_bad |=> !CLOCK2_BAD_OUTPUT_O) else $error("clock bad polarity");
  a_reg_read_back: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_ALARM_CFG |=> REG_RDATA_O == $past(alarm_reg)) else $error("readback wrong");

endmodule : clock_alarm_status_pins

// *** bench/clock_alarm_host_model.sv ***
// host processor model driving the register strobes of the block
module clock_alarm_host_model (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = '0;
  end

  // one-cycle write strobe, bus inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr

  // read data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : clock_alarm_host_model

// *** bench/clock_alarm_status_pins_tb_top.sv ***
// self-checking testbench of the clock alarm status pin block
module clock_alarm_status_pins_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, arst_n, wr, rd, slip, c1_act, auto_mode, sel_pin;
  logic [7:0] addr, wdata, rdata, ppm, d;
  logic [2:0] loss_raw, loss, ref_sel;
  logic [1:0] offset_raw, offset_en, reg_sel, offset_al, sel_clk, auto_sel;
  logic       lock, c2, c2_oe, sh, sh_oe, lk, lk_oe, sa, sa_oe;
  int         n_errors = 0;
  int         comparisons = 0;
  logic [7:0] ra [5] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h20};
  logic [7:0] rv [5] = '{8'h2C, 8'h3E, 8'hFF, 8'hDF, 8'h00};
  logic [7:0] wv [5] = '{8'h00, 8'h30, 8'hFC, 8'hD0, 8'h00};
  logic [7:0] th [4] = '{8'h0C, 8'h31, 8'h1E, 8'hC8};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  clock_alarm_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

  clock_alarm_status_pins #(.TICK_CYCLES_P(2)) dut (
    .CLK_I(clk), .ARST_N_I(arst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .SIGNAL_LOSS_RAW_I(loss_raw), .FREQ_OFFSET_RAW_I(offset_raw),
    .PER_INPUT_OFFSET_ENABLE_I(offset_en), .PHASE_SLIP_I(slip), .CLOCK1_ACTIVE_STATUS_I(c1_act),
    .AUTO_SELECTION_MODE_I(auto_mode), .REGISTER_CLOCK_SELECT_I(reg_sel), .AUTO_CLOCK_SELECT_I(auto_sel),
    .SELECT_ACTIVE_PIN_I(sel_pin), .SIGNAL_LOSS_ALARM_O(loss), .FREQUENCY_OFFSET_ALARM_O(offset_al),
    .LOCK_LOSS_O(lock), .OFFSET_THRESHOLD_PPM_O(ppm), .OFFSET_REFERENCE_SELECT_O(ref_sel),
    .SELECTED_CLOCK_O(sel_clk), .CLOCK2_BAD_OUTPUT_O(c2), .CLOCK2_BAD_OUTPUT_OE_O(c2_oe),
    .SHARED_INTERRUPT_CLOCK1_BAD_PIN_O(sh), .SHARED_INTERRUPT_CLOCK1_BAD_PIN_OE_O(sh_oe),
    .LOCK_LOSS_PIN_O(lk), .LOCK_LOSS_PIN_OE_O(lk_oe), .SELECT_ACTIVE_PIN_O(sa), .SELECT_ACTIVE_PIN_OE_O(sa_oe));

  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task automatic pins(input logic [5:0] exp);
    settle();
    check("pins", {2'b00, c2_oe, c2, sh_oe, sh, lk_oe, lk}, {2'b00, exp});
  endtask : pins

  task automatic wait_fall(input logic lock_side, input int bound);
    int k;
    k = 0;
    while ((lock_side ? lock : loss[0]) !== 1'b0 && k < bound) begin
      @(posedge clk);
      #1;
      k++;
    end
    if ((lock_side ? lock : loss[0]) !== 1'b0) begin
      check("timeout", 8'h00, 8'h01);
      end_of_test();
    end
  endtask : wait_fall

  initial begin
    {arst_n, slip, c1_act, auto_mode, sel_pin} = 5'b00110;
    {loss_raw, offset_raw, offset_en, reg_sel, auto_sel} = 11'b11111111011;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i]) begin
      host.rd(ra[i], d);
      check("reset value", d, rv[i]);
    end
    foreach (ra[i]) host.wr(ra[i], 8'h00);
    foreach (ra[i]) begin
      host.rd(ra[i], d);
      check("read-only bits", d, wv[i]);
    end
    check("pin enables", {5'h00, c2_oe, sh_oe, lk_oe}, 8'h00);
    check("auto select", {6'h00, sel_clk}, 8'h03);
    host.wr(8'h14, 8'h0E);
    pins(6'b101011);
    host.wr(8'h16, 8'h07);
    pins(6'b111110);
    host.wr(8'h14, 8'h0F);
    pins(6'b111010);
    host.wr(8'h17, 8'h00);
    pins(6'b111110);
    host.wr(8'h16, 8'h06);
    pins(6'b111010);
    host.wr(8'h14, 8'h0B);
    pins(6'b110010);
    check("offset alarm", {6'h00, offset_al}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h13, {1'b1, 2'(i), 5'h00});
      settle();
      check("threshold", ppm, th[i]);
    end
    check("offset alarm", {6'h00, offset_al}, 8'h03);
    @(posedge clk) offset_en <= 2'b01;
    settle();
    check("offset alarm", {6'h00, offset_al}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h07, 8'(i));
      settle();
      check("reference", {5'h00, ref_sel}, (i < 3) ? 8'(i) : 8'h00);
    end
    @(posedge clk) auto_mode <= 1'b0;
    host.wr(8'h16, 8'h0F);
    host.wr(8'h15, 8'h02);
    settle();
    check("register select", {6'h00, sel_clk}, 8'h02);
    check("active pin", {6'h00, sa_oe, sa}, 8'h03);
    host.wr(8'h16, 8'h07);
    settle();
    check("active pin", {6'h00, sa_oe, sa}, 8'h02);
    @(posedge clk) sel_pin <= 1'b1;
    host.wr(8'h15, 8'h03);
    settle();
    check("pin select", {6'h00, sel_clk}, 8'h01);
    check("active pin oe", {7'h00, sa_oe}, 8'h00);
    host.wr(8'h13, 8'h06);
    @(posedge clk) loss_raw[0] <= 1'b0;
    repeat (300) @(posedge clk);
    #1;
    check("loss held", {7'h00, loss[0]}, 8'h01);
    wait_fall(1'b0, 200);
    @(posedge clk) loss_raw[0] <= 1'b1;
    settle();
    check("loss raised", {7'h00, loss[0]}, 8'h01);
    @(posedge clk) slip <= 1'b1;
    @(posedge clk) slip <= 1'b0;
    settle();
    check("lock loss", {6'h00, lock, lk}, 8'h03);
    repeat (290) @(posedge clk);
    #1;
    check("lock held", {7'h00, lock}, 8'h01);
    wait_fall(1'b1, 100);
    host.wr(8'h13, 8'h07);
    @(posedge clk) slip <= 1'b1;
    @(posedge clk) slip <= 1'b0;
    repeat (20000) @(posedge clk);
    #1;
    check("reserved interval", {7'h00, lock}, 8'h01);
    wait_fall(1'b1, 25000);
    end_of_test();
  end
endmodule : clock_alarm_status_pins_tb_top
